// >>> brr_boot_read.sv
// boot-at-reset read sequencer with boot register read and write commands
// Function
// - enabled boot read starts armed from every reset
// - hold data for configured 4-bit delay count
// - quad bit selects four-line or one-line format
// - first address comes from start address field
// - stream consecutive bytes while select stays low
// - select high returns to single-line command mode
// - boot read never repeats until next reset or software reset command
// - boot read only when enable bit set
// - config register kept in retained storage
// - command 14h reads register, low byte first
// - register read repeats while select low
// - register write 15h needs set unlock latch
// - exactly 32 bits, write starts at select high
// - write in progress reads one until done
// - finished register write clears unlock latch
`timescale 1ns/1ps

module brr_boot_read
    import brr_pkg::*;
(
    input  wire logic        core_clk,       // system clock, 100 MHz
    input  wire logic        reset,          // asynchronous reset, active high
    input  wire logic        spi_cs_n,       // chip select pin, active low
    input  wire logic        spi_sck,        // serial clock pin
    input  wire logic [3:0]  spi_io_in,      // data pins, input side
    output logic      [3:0]  spi_io_out,     // data pins, output side
    output logic      [3:0]  spi_io_oe,      // data pins, drive enable
    input  wire logic        quad_lines_on,  // status quad enable bit
    input  wire logic [31:0] nv_config,      // retained boot_read_config value
    output logic             nv_write,       // one-cycle store strobe
    output logic      [31:0] nv_write_data,  // value stored on nv_write
    output logic      [23:0] mem_addr,       // array byte address
    input  wire logic [7:0]  mem_data        // array byte at mem_addr
);

    brr_regs_type r_reg;   // registered state
    brr_regs_type r_next;  // next state

    // config register byte-wise, msb-first bit index for serial position c
    function automatic logic [4:0] ser_index(input logic [5:0] c);
        ser_index = {c[4:3], ~c[2:0]};
    endfunction : ser_index

    logic       sck_rise;  // serial clock rising edge
    logic       sck_fall;  // serial clock falling edge
    logic       cs_fall;   // select asserted
    logic       cs_rise;   // select released
    logic [7:0] status;    // status byte as read out
    logic [7:0] cmd_full;  // command including the bit taken now

    // edge finders look at the second sync stage only
    assign sck_rise = r_reg.sck_s2 & ~r_reg.sck_prev;
    assign sck_fall = ~r_reg.sck_s2 & r_reg.sck_prev;
    assign cs_fall  = ~r_reg.cs_s2 & r_reg.cs_prev;
    assign cs_rise  = r_reg.cs_s2 & ~r_reg.cs_prev;
    assign cmd_full = {r_reg.cmd[6:0], r_reg.di_s2};

    // status byte with progress and latch flags
    always_comb begin
        status               = 8'h00;
        status[STAT_WIP_BIT] = r_reg.write_in_progress;
        status[STAT_WEL_BIT] = r_reg.write_unlock_latch;
        status[STAT_QE_BIT]  = quad_lines_on;
    end

    // next-state logic
    always_comb begin
        r_next          = r_reg;
        r_next.nv_wr    = 1'b0;
        // two-stage synchronisers for the pins
        r_next.cs_s1    = spi_cs_n;
        r_next.cs_s2    = r_reg.cs_s1;
        r_next.cs_prev  = r_reg.cs_s2;
        r_next.sck_s1   = spi_sck;
        r_next.sck_s2   = r_reg.sck_s1;
        r_next.sck_prev = r_reg.sck_s2;
        r_next.di_s1    = spi_io_in[0];
        r_next.di_s2    = r_reg.di_s1;

        // internal register write timer
        if (r_reg.write_in_progress) begin
            if (r_reg.busy_cnt == 16'h0000) begin
                r_next.write_in_progress = 1'b0;
                r_next.write_unlock_latch = 1'b0;
            end else begin
                r_next.busy_cnt = r_reg.busy_cnt - 16'h0001;
            end
        end

        if (cs_rise) begin
            // select high ends any phase, back to single-line mode
            r_next.state  = ST_IDLE;
            r_next.io_oe  = 4'h0;
            // write only with exactly 32 data bits
            if (r_reg.state == ST_WR_CFG && r_reg.cnt == 6'(CFG_BITS)) begin
                r_next.write_in_progress      = 1'b1;
                r_next.busy_cnt = WRITE_CYCLES_W;
                r_next.nv_wr    = 1'b1;
                r_next.nv_wdata = r_reg.wr_data;
            end
            if (r_reg.soft_rst) begin
                r_next.armed    = 1'b1;     // software reset re-arms
                r_next.soft_rst = 1'b0;
            end
        end else if (cs_fall) begin
            r_next.cnt = 6'h00;
            r_next.cmd = 8'h00;
            r_next.armed = 1'b0;            // only the first select after a reset or software reset may boot
            if (r_reg.armed && nv_config[CFG_ON_BIT] && !r_reg.write_in_progress) begin
                // boot read, no command expected
                r_next.addr      = nv_config[CFG_ADDR_LSB +: 24];
                r_next.delay_cnt = nv_config[CFG_DELAY_LSB +: 4];
                r_next.quad      = quad_lines_on;
                r_next.state     = ST_BOOT_WAIT;
                r_next.io_oe     = quad_lines_on ? 4'hF : 4'h2;
                // a zero delay is served in the wait state, once mem_addr shows the start address
            end else begin
                r_next.state = ST_CMD;
            end
        end else begin
            unique case (r_reg.state)
                ST_IDLE: begin
                    // waits for select
                end
                ST_BOOT_WAIT: begin
                    // count delay clocks, host is silent meanwhile
                    if (r_reg.delay_cnt == 4'h0) begin
                        // zero delay: first bit one cycle after select, before the first clock
                        r_next.state  = ST_BOOT_DATA;
                        r_next.io_out = r_reg.quad ? mem_data[7:4] : {2'b00, mem_data[7], 1'b0};
                        r_next.cnt    = 6'h01;
                    end else if (sck_fall) begin
                        r_next.delay_cnt = r_reg.delay_cnt - 4'h1;
                        if (r_reg.delay_cnt == 4'h1) begin
                            r_next.state  = ST_BOOT_DATA;
                            r_next.io_out = r_reg.quad ? mem_data[7:4] : {2'b00, mem_data[7], 1'b0};
                            r_next.cnt    = 6'h01;
                        end
                    end
                end
                ST_BOOT_DATA: begin
                    // stream bytes on falling edges
                    if (sck_fall) begin
                        if (r_reg.quad) begin
                            // two nibbles per byte, high first
                            r_next.io_out = r_reg.cnt[0] ? mem_data[3:0] : mem_data[7:4];
                            r_next.cnt    = {5'h00, ~r_reg.cnt[0]};
                            if (r_reg.cnt[0]) begin
                                r_next.addr = r_reg.addr + 24'h000001;
                            end
                        end else begin
                            r_next.io_out = {2'b00, mem_data[3'h7 - r_reg.cnt[2:0]], 1'b0};
                            r_next.cnt    = {3'h0, r_reg.cnt[2:0] + 3'h1};
                            if (r_reg.cnt[2:0] == 3'h7) begin
                                r_next.addr = r_reg.addr + 24'h000001;
                            end
                        end
                    end
                end
                ST_CMD: begin
                    // shift in the code on rising edges, msb first
                    if (sck_rise) begin
                        r_next.cmd = cmd_full;
                        r_next.cnt = r_reg.cnt + 6'h01;
                        if (r_reg.cnt == 6'h07) begin
                            r_next.cnt   = 6'h00;
                            r_next.state = ST_IGNORE;
                            if (cmd_full == CMD_STATUS_READ) begin
                                r_next.state = ST_STATUS;          // readable while busy
                            end else if (!r_reg.write_in_progress) begin
                                // other commands refused during a write
                                if (cmd_full == CMD_WRITE_UNLOCK) begin
                                    r_next.write_unlock_latch = 1'b1;
                                end else if (cmd_full == CMD_WRITE_LOCK) begin
                                    r_next.write_unlock_latch = 1'b0;
                                end else if (cmd_full == CMD_BOOT_REG_READ) begin
                                    r_next.state = ST_RD_CFG;
                                end else if (cmd_full == CMD_BOOT_REG_WRITE && r_reg.write_unlock_latch) begin
                                    r_next.state   = ST_WR_CFG;
                                    r_next.wr_data = nv_config;
                                end else if (cmd_full == CMD_SOFT_RESET) begin
                                    r_next.soft_rst = 1'b1;
                                end
                            end
                        end
                    end
                end
                ST_RD_CFG: begin
                    // low byte first, msb of each byte first, wraps every 32 bits
                    if (sck_fall) begin
                        r_next.io_oe  = 4'h2;
                        r_next.io_out = {2'b00, nv_config[ser_index(r_reg.cnt)], 1'b0};
                        r_next.cnt    = {1'b0, r_reg.cnt[4:0] + 5'h01};
                    end
                end
                ST_WR_CFG: begin
                    // gather data bits in the same order, count past 32 to spot excess
                    if (sck_rise) begin
                        if (r_reg.cnt < 6'(CFG_BITS)) begin
                            r_next.wr_data[ser_index(r_reg.cnt)] = r_reg.di_s2;
                        end
                        if (r_reg.cnt != 6'h3F) begin
                            r_next.cnt = r_reg.cnt + 6'h01;
                        end
                    end
                end
                ST_STATUS: begin
                    // status byte repeated, msb first
                    if (sck_fall) begin
                        r_next.io_oe  = 4'h2;
                        r_next.io_out = {2'b00, status[3'h7 - r_reg.cnt[2:0]], 1'b0};
                        r_next.cnt    = {3'h0, r_reg.cnt[2:0] + 3'h1};
                    end
                end
                ST_IGNORE: begin
                    // nothing until select high
                end
                default: begin
                    r_next.state = ST_IDLE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            r_reg          <= '0;
            r_reg.cs_s1    <= 1'b1;
            r_reg.cs_s2    <= 1'b1;
            r_reg.cs_prev  <= 1'b1;
            r_reg.state    <= ST_IDLE;
            r_reg.armed    <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from flip-flops
    assign spi_io_out    = r_reg.io_out;
    assign spi_io_oe     = r_reg.io_oe;
    assign nv_write      = r_reg.nv_wr;
    assign nv_write_data = r_reg.nv_wdata;
    assign mem_addr      = r_reg.addr;

endmodule : brr_boot_read

// >>> brr_pkg.sv
// package with constants, field layout and types of the boot-at-reset read block
package brr_pkg;

    // serial command codes
    localparam logic [7:0] CMD_WRITE_UNLOCK    = 8'h06;  // write_unlock_cmd, sets the latch
    localparam logic [7:0] CMD_WRITE_LOCK      = 8'h04;  // clears the latch
    localparam logic [7:0] CMD_STATUS_READ     = 8'h05;  // status byte read
    localparam logic [7:0] CMD_BOOT_REG_READ   = 8'h14;  // boot_reg_read_cmd
    localparam logic [7:0] CMD_BOOT_REG_WRITE  = 8'h15;  // boot_reg_write_cmd
    localparam logic [7:0] CMD_SOFT_RESET      = 8'h99;  // software reset, re-arms boot read

    // boot_read_config field layout
    localparam int CFG_ON_BIT      = 0;   // boot_feature_on
    localparam int CFG_DELAY_LSB   = 1;   // boot_delay_count, 4 bits
    localparam int CFG_ADDR_LSB    = 8;   // boot_start_addr, 24 bits
    localparam int CFG_BITS        = 32;  // register width in bits

    // status byte bit positions
    localparam int STAT_WIP_BIT    = 0;   // write_in_progress
    localparam int STAT_WEL_BIT    = 1;   // write_unlock_latch
    localparam int STAT_QE_BIT     = 6;   // quad_lines_on

    // internal register write time
    localparam int WRITE_TIME_NS   = 2000;                         // time of one register write
    localparam int CLK_PERIOD_NS   = 10;                           // core_clk period
    localparam int WRITE_CYCLES    = WRITE_TIME_NS / CLK_PERIOD_NS; // rounded down, longest time
    localparam logic [15:0] WRITE_CYCLES_W = 16'(WRITE_CYCLES);

    // sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_IDLE      = 8'h01,  // chip select high
        ST_BOOT_WAIT = 8'h02,  // boot read initial delay
        ST_BOOT_DATA = 8'h04,  // boot read streaming
        ST_CMD       = 8'h08,  // shifting in command code
        ST_RD_CFG    = 8'h10,  // shifting out config register
        ST_WR_CFG    = 8'h20,  // shifting in config register data
        ST_STATUS    = 8'h40,  // shifting out status byte
        ST_IGNORE    = 8'h80   // waits for chip select high
    } brr_state_type;

    // complete state of the block
    typedef struct packed {
        logic          cs_s1;      // chip select sync stage 1
        logic          cs_s2;      // chip select sync stage 2
        logic          cs_prev;    // delayed stage 2 for edges
        logic          sck_s1;     // serial clock sync stage 1
        logic          sck_s2;     // serial clock sync stage 2
        logic          sck_prev;   // delayed stage 2 for edges
        logic          di_s1;      // io0 sync stage 1
        logic          di_s2;      // io0 sync stage 2
        brr_state_type state;      // sequencer state
        logic          armed;      // boot read still allowed
        logic          soft_rst;   // software reset pending until chip select high
        logic          write_unlock_latch;        // write_unlock_latch
        logic          write_in_progress;        // write_in_progress
        logic [15:0]   busy_cnt;   // cycles left of the internal write
        logic [5:0]    cnt;        // bit counter of the current phase
        logic [7:0]    cmd;        // command shift register
        logic [31:0]   wr_data;    // incoming config data
        logic [3:0]    delay_cnt;  // boot delay cycles left
        logic          quad;       // boot read uses four lines
        logic [23:0]   addr;       // boot read byte address
        logic [3:0]    io_out;     // data pin drive values
        logic [3:0]    io_oe;      // data pin enables
        logic          nv_wr;      // store strobe to the retained cells
        logic [31:0]   nv_wdata;   // value to store
    } brr_regs_type;

endpackage : brr_pkg

// >>> brr_boot_read_chk.sv
// port checks for the boot-at-reset read block
`timescale 1ns/1ps
module brr_boot_read_chk (
    input wire logic        core_clk,       // system clock
    input wire logic        reset,          // async reset, active high
    input wire logic        spi_cs_n,       // select pin
    input wire logic        spi_sck,        // serial clock pin
    input wire logic [3:0]  spi_io_out,     // data pin values
    input wire logic [3:0]  spi_io_oe,      // data pin enables
    input wire logic        quad_lines_on,  // quad enable status bit
    input wire logic        nv_write,       // store strobe
    input wire logic [31:0] nv_write_data,  // value to store
    input wire logic [23:0] mem_addr        // array address
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_rst_quiet; $fell(reset) |-> spi_io_oe == 4'h0 && !nv_write && mem_addr == 24'h000000; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("pins active after reset");
    property p_store_pulse; nv_write |=> !nv_write; endproperty
    a_store_pulse: assert property (p_store_pulse) else $error("store strobe too long");
    property p_store_at_rise; nv_write |-> spi_cs_n && $past(spi_cs_n, 2); endproperty
    a_store_at_rise: assert property (p_store_at_rise) else $error("store while selected");
    property p_release; spi_cs_n [*6] |-> spi_io_oe == 4'h0; endproperty
    a_release: assert property (p_release) else $error("pins driven after deselect");
    property p_oe_code; spi_io_oe inside {4'h0, 4'h2, 4'hF}; endproperty
    a_oe_code: assert property (p_oe_code) else $error("odd pin enable pattern");
    property p_quad_needs_qe; spi_io_oe == 4'hF |-> quad_lines_on; endproperty
    a_quad_needs_qe: assert property (p_quad_needs_qe) else $error("four lines without quad bit");
    property p_data_held; $changed(nv_write_data) |-> nv_write; endproperty
    a_data_held: assert property (p_data_held) else $error("store value moved");
    property p_out_on_fall; $changed(spi_io_out) && spi_io_oe != 4'h0 && $past(spi_io_oe) != 4'h0
        |-> !$past(spi_sck) && !$past(spi_sck, 2); endproperty
    a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off clock fall");
endmodule : brr_boot_read_chk

bind brr_boot_read brr_boot_read_chk u_chk (
    .core_clk(core_clk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_io_out(spi_io_out),
    .spi_io_oe(spi_io_oe), .quad_lines_on(quad_lines_on), .nv_write(nv_write), .nv_write_data(nv_write_data),
    .mem_addr(mem_addr)
);

// >>> brr_host.sv
// host serial master model facing the block
`timescale 1ns/1ps
module brr_host (
    output logic            spi_cs_n,  // select, active low
    output logic            spi_sck,   // clock, still between frames
    output logic            host_di,   // serial data to the block
    output logic            host_oe,   // host drives io0
    input  wire logic [3:0] io_wire    // resolved data pins
);
    localparam realtime HALF = 62.5;  // half of the 125 ns link period
    // idle link at time zero
    initial begin
        spi_cs_n = 1'b1;
        spi_sck  = 1'b0;
        host_di  = 1'b0;
        host_oe  = 1'b0;
    end
    // select falls, nothing else sent first
    task automatic open_frame();
        #HALF spi_cs_n = 1'b0;
    endtask : open_frame
    // select rises half a period after the last whole unit
    task automatic close_frame();
        #HALF spi_cs_n = 1'b1;
        host_oe = 1'b0;
    endtask : close_frame
    // n clocks: io0 msb first, capture io1 or the nibble at each rise
    task automatic shift(input int n, input logic [31:0] tx, input bit drive, input bit quad, output logic [31:0] rx);
        rx = '0;
        for (int i = 0; i < n; i++) begin
            host_oe = drive;
            host_di = tx[n-1-i];
            #HALF spi_sck = 1'b1;
            rx = quad ? {rx[27:0], io_wire} : {rx[30:0], io_wire[1]};
            #HALF spi_sck = 1'b0;
        end
    endtask : shift
endmodule : brr_host

// >>> brr_boot_read_bench.sv
// self-checking bench of the boot-at-reset read block
`timescale 1ns/1ps
module brr_boot_read_bench;
    import brr_pkg::*;
    localparam int LIMIT = 40000;                // cycle ceiling of the run
    localparam logic [31:0] CFG1 = 32'h00001007; // on, delay 3, start 0x10
    localparam logic [31:0] CFG2 = 32'h00002005; // on, delay 2, start 0x20
    localparam logic [31:0] CFG3 = 32'h0000300A; // off, delay 5, start 0x30
    logic        core_clk, reset, quad_lines_on, nv_write, spi_cs_n, spi_sck, host_di, host_oe, cfg_ld;
    bit          tog;                            // changes every cycle, starts low
    logic [3:0]  io_out, io_oe, io_wire;         // pin values and resolved wires
    logic [31:0] nv_config, nv_wdata, rx, cfg_val; // retained cells, store value, capture, preset
    logic [23:0] mem_addr;                       // array address
    logic [7:0]  mem_data;                       // array byte
    int          fails, checked, writes, cycles; // counters
    // block drives first, else host on io0, else a value changing every cycle
    always_comb for (int i = 0; i < 4; i++) io_wire[i] = io_oe[i] ? io_out[i] : (i == 0 && host_oe) ? host_di : tog;
    assign mem_data = mem_addr[7:0] ^ 8'h5A;     // array content pattern
    brr_host host (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .host_di(host_di), .host_oe(host_oe), .io_wire(io_wire));
    brr_boot_read dut (.core_clk(core_clk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_io_in(io_wire),
        .spi_io_out(io_out), .spi_io_oe(io_oe), .quad_lines_on(quad_lines_on), .nv_config(nv_config),
        .nv_write(nv_write), .nv_write_data(nv_wdata), .mem_addr(mem_addr), .mem_data(mem_data));
    // clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // retained cells, store counter and run ceiling
    always @(posedge core_clk) begin
        tog <= ~tog;
        cycles <= cycles + 1;
        if (nv_write === 1'b1) begin
            nv_config <= nv_wdata;
            writes <= writes + 1;
        end else if (cfg_ld === 1'b1) begin
            nv_config <= cfg_val;        // preset before a reset
        end
    end
    function automatic logic [31:0] sw(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};  // low byte goes first
    endfunction : sw
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked = checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic do_reset(input logic qe);
        @(posedge core_clk);
        cfg_ld <= 1'b0;
        reset <= 1'b1;
        quad_lines_on <= qe;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask : do_reset
    // one command frame with optional data bits
    task automatic send(input logic [7:0] c, input int n, input logic [31:0] d);
        host.open_frame();
        host.shift(8, {24'h000000, c}, 1'b1, 1'b0, rx);
        if (n > 0) begin
            host.shift(n, d, 1'b1, 1'b0, rx);
        end
        host.close_frame();
    endtask : send
    // config read, two turns in one frame
    task automatic reg_read(input logic [31:0] v, input string what);
        host.open_frame();
        host.shift(8, {24'h000000, CMD_BOOT_REG_READ}, 1'b1, 1'b0, rx);
        repeat (2) begin
            host.shift(32, 32'h00000000, 1'b0, 1'b0, rx);
            check(rx, sw(v), what);
        end
        host.close_frame();
    endtask : reg_read
    task automatic status(input logic [7:0] exp, input string what);
        send(CMD_STATUS_READ, 0, 32'h00000000);
        host.open_frame();
        host.shift(8, {24'h000000, CMD_STATUS_READ}, 1'b1, 1'b0, rx);
        host.shift(8, 32'h00000000, 1'b0, 1'b0, rx);
        check(rx, {24'h000000, exp}, what);
        host.close_frame();
    endtask : status
    task automatic t_boot_single();
        @(posedge core_clk);
        cfg_val <= CFG1;
        cfg_ld <= 1'b1;
        do_reset(1'b0);
        host.open_frame();
        host.shift(3, 32'h00000000, 1'b0, 1'b0, rx);
        host.shift(16, 32'h00000000, 1'b0, 1'b0, rx);
        check(rx, 32'h00004A4B, "single boot bytes");
        host.close_frame();
        reg_read(CFG1, "config after boot");
        $display("test boot_single done");
    endtask : t_boot_single
    task automatic t_write();
        int n0;
        n0 = writes;
        send(CMD_BOOT_REG_WRITE, 32, sw(CFG2));
        repeat (10) @(posedge core_clk);
        check(32'(writes - n0), 32'h00000000, "write without latch");
        send(CMD_WRITE_UNLOCK, 0, 32'h00000000);
        send(CMD_BOOT_REG_WRITE, 31, sw(CFG2) >> 1);
        repeat (10) @(posedge core_clk);
        check(32'(writes - n0), 32'h00000000, "short write");
        send(CMD_WRITE_LOCK, 0, 32'h00000000);
        send(CMD_BOOT_REG_WRITE, 32, sw(CFG2));
        repeat (10) @(posedge core_clk);
        check(32'(writes - n0), 32'h00000000, "write after lock");
        send(CMD_WRITE_UNLOCK, 0, 32'h00000000);
        send(CMD_BOOT_REG_WRITE, 32, sw(CFG2));
        host.open_frame();
        host.shift(8, {24'h000000, CMD_STATUS_READ}, 1'b1, 1'b0, rx);
        host.shift(8, 32'h00000000, 1'b0, 1'b0, rx);
        check(rx, 32'h00000003, "busy status");
        host.close_frame();
        repeat (300) @(posedge core_clk);
        status(8'h00, "idle status");
        check(32'(writes - n0), 32'h00000001, "one store");
        check(nv_config, CFG2, "stored value");
        $display("test write done");
    endtask : t_write
    task automatic t_boot_quad();
        do_reset(1'b1);
        host.open_frame();
        host.shift(2, 32'h00000000, 1'b0, 1'b1, rx);
        host.shift(4, 32'h00000000, 1'b0, 1'b1, rx);
        check(rx, 32'h00007A7B, "quad boot bytes");
        host.close_frame();
        reg_read(CFG2, "single line after quad boot");
        send(CMD_SOFT_RESET, 0, 32'h00000000);
        host.open_frame();
        host.shift(2, 32'h00000000, 1'b0, 1'b1, rx);
        host.shift(4, 32'h00000000, 1'b0, 1'b1, rx);
        check(rx, 32'h00007A7B, "boot after software reset");
        host.close_frame();
        $display("test boot_quad done");
    endtask : t_boot_quad
    task automatic t_disabled();
        @(posedge core_clk);
        cfg_val <= CFG3;
        cfg_ld <= 1'b1;
        do_reset(1'b0);
        reg_read(CFG3, "first select takes command");
        $display("test disabled done");
    endtask : t_disabled
    task automatic results();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    // main sequence
    initial begin
        reset = 1'b1;
        quad_lines_on = 1'b0;
        cfg_ld = 1'b0;
        fails = 0;
        checked = 0;
        fork
            begin
                t_boot_single();
                t_write();
                t_boot_quad();
                t_disabled();
            end
            begin
                // run ceiling counts as a mismatch
                wait (cycles == LIMIT);
                fails = fails + 1;
                $display("[FAIL] %0t run ceiling reached", $time);
            end
        join_any
        results();
    end
endmodule : brr_boot_read_bench
